// *** shared/bplc_params.svh ***
// bplc_params.svh: offsets, field positions and reset values of the general control fields
// assumes a byte-addressed configuration space reached by dword-aligned requests
`ifndef BPLC_PARAMS_SVH
`define BPLC_PARAMS_SVH
`define BPLC_GEN_CTRL_OFFSET 12'h0d4
`define BPLC_CLK_MASK_OFFSET 12'h0d8
`define BPLC_SPR_HI 22
`define BPLC_SPR_LO 20
`define BPLC_RLI_BIT 19
`define BPLC_SEL_HI 18
`define BPLC_SEL_LO 16
`define BPLC_DIL_HI 15
`define BPLC_DIL_LO 13
`define BPLC_VC_BIT 12
`define BPLC_D3S_BIT 11
`define BPLC_BCN_BIT 10
`define BPLC_SPR_RESET 3'h0
`define BPLC_LAT_RESET 3'h0
`define BPLC_CAP_SEL_LO 6
`define BPLC_CAP_DIL_LO 9
`define BPLC_CLK_COUNT 7
`endif

// *** shared/bplc_pkg.sv ***
// bplc_pkg: types of the bridge power and link control fields
// assumes the params header is included by users for numbers
package bplc_pkg;
	typedef enum logic [2:0] {
		BPLC_SPR_IGNORE,
		BPLC_SPR_INDICATE,
		BPLC_SPR_CLKSTOP,
		BPLC_SPR_BOTH,
		BPLC_SPR_UNSUP,
		BPLC_SPR_RSV5,
		BPLC_SPR_RSV6,
		BPLC_SPR_RSV7
	} bplc_spr_e;
	typedef struct packed {
		logic [2:0] slot_power_response_select;
		logic read_lookahead_inhibit;
		logic [2:0] standby_exit_latency_field;
		logic [2:0] deep_idle_exit_latency_field;
	} bplc_volatile_s;
	typedef struct packed {
		logic secondary_clock_stop_in_d3;
		logic beacon_select;
	} bplc_sticky_s;
	typedef struct packed {
		logic valid;
		logic [11:0] addr;
		logic write;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} bplc_cfg_req_s;
	typedef struct packed {
		logic is_config;
		logic is_slot_power_msg;
		logic is_mem_read;
		logic is_mem_read_line;
		logic is_mem_read_multiple;
	} bplc_txn_s;
endpackage

// *** rtl/bplc_volatile_fields.sv ***
// bplc_volatile_fields: bits 22:13 of general control, cleared by any of three resets
// assumes config writes arrive as one-cycle strobes with byte enables
`timescale 1ns/1ps
`default_nettype none
`include "bplc_params.svh"
module bplc_volatile_fields (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic link_reset,
	input wire logic global_reset_input,
	input wire logic wr_en,
	input wire logic [3:0] byte_en,
	input wire logic [31:0] wdata,
	output bplc_pkg::bplc_volatile_s fields
);
	bplc_pkg::bplc_volatile_s state_reg, state_next;
	always_comb begin
		state_next = state_reg;
		if (wr_en && byte_en[2]) begin
			state_next.slot_power_response_select = wdata[`BPLC_SPR_HI:`BPLC_SPR_LO];
			state_next.read_lookahead_inhibit = wdata[`BPLC_RLI_BIT];
			state_next.standby_exit_latency_field = wdata[`BPLC_SEL_HI:`BPLC_SEL_LO];
		end
		if (wr_en && byte_en[1]) begin
			state_next.deep_idle_exit_latency_field[2] = wdata[`BPLC_DIL_HI];
			state_next.deep_idle_exit_latency_field[1] = wdata[`BPLC_DIL_HI-1];
		end
		if (wr_en && byte_en[1]) begin
			state_next.deep_idle_exit_latency_field[0] = wdata[`BPLC_DIL_LO];
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst || link_reset || global_reset_input) begin
			state_reg.slot_power_response_select <= `BPLC_SPR_RESET;
			state_reg.read_lookahead_inhibit <= 1'b0;
			state_reg.standby_exit_latency_field <= `BPLC_LAT_RESET;
			state_reg.deep_idle_exit_latency_field <= `BPLC_LAT_RESET;
		end else begin
			state_reg <= state_next;
		end
	end
	assign fields = state_reg;
endmodule // bplc_volatile_fields
`default_nettype wire

// *** rtl/bplc_sticky_fields.sv ***
// bplc_sticky_fields: bits 11:10 of general control, kept while on auxiliary power
// assumes aux_power_good low only at a true cold start of the aux well
`timescale 1ns/1ps
`default_nettype none
`include "bplc_params.svh"
module bplc_sticky_fields (
	input wire logic core_clk,
	input wire logic aux_por,
	input wire logic wr_en,
	input wire logic [3:0] byte_en,
	input wire logic [31:0] wdata,
	output bplc_pkg::bplc_sticky_s fields
);
	bplc_pkg::bplc_sticky_s state_reg, state_next;
	always_comb begin
		state_next = state_reg;
		if (wr_en && byte_en[1]) begin
			state_next.secondary_clock_stop_in_d3 = wdata[`BPLC_D3S_BIT];
			state_next.beacon_select = wdata[`BPLC_BCN_BIT];
		end
	end
	always_ff @(posedge core_clk) begin
		if (aux_por) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign fields = state_reg;
endmodule // bplc_sticky_fields
`default_nettype wire

// *** rtl/bplc_ctrl.sv ***
// bplc_ctrl: general control bits 22:10 and the actions they steer
// assumes config requests and transaction classes come from the link core, one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "bplc_params.svh"
// Summary of operation
// - slot-power response acts only when slot limit below required power; zero ignores.
// - code 001 with limit exceeded drives the power-exceed indicator only.
// - code 010 with limit exceeded stops clocks chosen by the clock mask.
// - code 011 stops mask-selected clocks and drives the indicator.
// - code 100 answers unsupported to all but config and slot-power messages.
// - inhibit clear makes read, read line and read multiple prefetchable.
// - inhibit set makes only read line and read multiple prefetchable.
// - standby-exit latency field is advertised in capability bits 8:6.
// - standby code 000 below 64 ns, doubling, 111 above 4 us.
// - deep-idle exit latency field is advertised in capability bits 11:9.
// - deep-idle code 000 below 1 us, doubling, 111 above 64 us.
// - virtual-channel present bit is read-only zero.
// - clock-stop bit set stops secondary clocks in D3.
// - wake select clear uses sideband wake; set uses beacon plus wake.
// - bits 22:12 reset by link reset, global reset or power-on reset.
// - D3 clock-stop and wake select bits are sticky on aux power.
module bplc_ctrl (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic link_reset,
	input wire logic global_reset_input,
	input wire logic aux_por,
	input wire bplc_pkg::bplc_cfg_req_s cfg_req,
	input wire bplc_pkg::bplc_txn_s txn,
	input wire logic txn_valid,
	input wire logic slot_power_short,
	input wire logic in_d3,
	input wire logic wake_request,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	output logic power_exceed_indicator_pin,
	output logic [`BPLC_CLK_COUNT-1:0] secondary_clock_enable,
	output logic txn_unsupported,
	output logic txn_prefetchable,
	output logic txn_done,
	output logic [2:0] advertised_standby_exit_latency,
	output logic [2:0] advertised_deep_idle_exit_latency,
	output logic virtual_channel_struct_present,
	output logic wake_sideband_out,
	output logic wake_beacon_out
);
	typedef struct packed {
		logic [31:0] rdata;
		logic rvalid;
		logic indicator;
		logic [`BPLC_CLK_COUNT-1:0] clk_en;
		logic [`BPLC_CLK_COUNT-1:0] clk_mask;
		logic unsup;
		logic prefetch;
		logic done;
		logic [2:0] sel_adv;
		logic [2:0] dil_adv;
		logic wake_sb;
		logic wake_bcn;
		logic vc_present;
	} bplc_state_s;
	bplc_state_s st_reg, st_next;
	bplc_pkg::bplc_volatile_s vf;
	bplc_pkg::bplc_sticky_s sf;
	bplc_pkg::bplc_spr_e spr;
	logic gc_wr;
	logic gc_hit;
	logic mask_hit;
	logic exceeded;
	logic stop_by_power;
	logic stop_by_d3;
	logic [31:0] gc_word;

	assign gc_hit = cfg_req.addr == `BPLC_GEN_CTRL_OFFSET;
	assign mask_hit = cfg_req.addr == `BPLC_CLK_MASK_OFFSET;
	assign gc_wr = cfg_req.valid && cfg_req.write && gc_hit;

	bplc_volatile_fields u_volatile (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.link_reset(link_reset),
		.global_reset_input(global_reset_input),
		.wr_en(gc_wr),
		.byte_en(cfg_req.byte_en),
		.wdata(cfg_req.wdata),
		.fields(vf)
	);
	bplc_sticky_fields u_sticky (
		.core_clk(core_clk),
		.aux_por(aux_por),
		.wr_en(gc_wr),
		.byte_en(cfg_req.byte_en),
		.wdata(cfg_req.wdata),
		.fields(sf)
	);

	function automatic logic spr_indicates(input bplc_pkg::bplc_spr_e c);
		return (c == bplc_pkg::BPLC_SPR_INDICATE) || (c == bplc_pkg::BPLC_SPR_BOTH);
	endfunction
	function automatic logic spr_stops(input bplc_pkg::bplc_spr_e c);
		return (c == bplc_pkg::BPLC_SPR_CLKSTOP) || (c == bplc_pkg::BPLC_SPR_BOTH);
	endfunction

	always_comb begin
		spr = bplc_pkg::bplc_spr_e'(vf.slot_power_response_select);
		exceeded = slot_power_short;
		gc_word = 32'h0000_0000;
		gc_word[`BPLC_SPR_HI:`BPLC_SPR_LO] = vf.slot_power_response_select;
		gc_word[`BPLC_RLI_BIT] = vf.read_lookahead_inhibit;
		gc_word[`BPLC_SEL_HI:`BPLC_SEL_LO] = vf.standby_exit_latency_field;
		gc_word[`BPLC_DIL_HI:`BPLC_DIL_LO] = vf.deep_idle_exit_latency_field;
		gc_word[`BPLC_VC_BIT] = 1'b0;
		gc_word[`BPLC_D3S_BIT] = sf.secondary_clock_stop_in_d3;
		gc_word[`BPLC_BCN_BIT] = sf.beacon_select;
	end

	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		st_next.done = 1'b0;
		if (cfg_req.valid && cfg_req.write && mask_hit && cfg_req.byte_en[1]) begin
			st_next.clk_mask = cfg_req.wdata[8 +: `BPLC_CLK_COUNT];
		end
		if (cfg_req.valid && !cfg_req.write) begin
			st_next.rvalid = 1'b1;
			if (gc_hit) begin
				st_next.rdata = gc_word;
			end else if (mask_hit) begin
				st_next.rdata = {16'h0000, 1'b0, st_reg.clk_mask, 8'h00};
			end else begin
				st_next.rdata = 32'h0000_0000;
			end
		end
		st_next.indicator = exceeded && spr_indicates(spr);
		stop_by_power = exceeded && spr_stops(spr);
		stop_by_d3 = in_d3 && sf.secondary_clock_stop_in_d3;
		if (stop_by_d3) begin
			st_next.clk_en = '0;
		end else if (stop_by_power) begin
			st_next.clk_en = ~st_reg.clk_mask;
		end else begin
			st_next.clk_en = '1;
		end
		if (txn_valid) begin
			st_next.done = 1'b1;
			// unsupported except config and slot messages
			st_next.unsup = exceeded && (spr == bplc_pkg::BPLC_SPR_UNSUP) && !txn.is_config
				&& !txn.is_slot_power_msg;
			st_next.prefetch = txn.is_mem_read_line || txn.is_mem_read_multiple
				|| (txn.is_mem_read && !vf.read_lookahead_inhibit);
		end
		st_next.sel_adv = vf.standby_exit_latency_field;
		st_next.dil_adv = vf.deep_idle_exit_latency_field;
		st_next.wake_sb = wake_request;
		st_next.wake_bcn = wake_request && sf.beacon_select;
		st_next.vc_present = 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || link_reset || global_reset_input) begin
			st_reg <= '0;
			st_reg.clk_en <= '1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign cfg_rdata = st_reg.rdata;
	assign cfg_rvalid = st_reg.rvalid;
	assign power_exceed_indicator_pin = st_reg.indicator;
	assign secondary_clock_enable = st_reg.clk_en;
	assign txn_unsupported = st_reg.unsup;
	assign txn_prefetchable = st_reg.prefetch;
	assign txn_done = st_reg.done;
	assign advertised_standby_exit_latency = st_reg.sel_adv;
	assign advertised_deep_idle_exit_latency = st_reg.dil_adv;
	assign virtual_channel_struct_present = st_reg.vc_present;
	assign wake_sideband_out = st_reg.wake_sb;
	assign wake_beacon_out = st_reg.wake_bcn;
endmodule // bplc_ctrl
`default_nettype wire

// *** tb/bplc_host_model.sv ***
// bplc_host_model: upstream host issuing configuration requests
// assumes the bench calls xfer just after a rising edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module bplc_host_model (
	input wire logic core_clk,
	output var bplc_pkg::bplc_cfg_req_s cfg_req
);
	initial cfg_req = '0;
	task automatic xfer(input logic [11:0] a, input logic w, input logic [3:0] be, input logic [31:0] d);
		cfg_req <= '{1'b1, a, w, be, d};
		@(posedge core_clk);
		// released lines flip so a stale address or data cannot pass as held
		cfg_req <= '{1'b0, ~a, 1'b0, 4'h0, ~d};
	endtask
endmodule // bplc_host_model
`default_nettype wire

// *** tb/bplc_ctrl_monitor.sv ***
// bplc_ctrl_monitor: port checks of the general control block
// assumes it is bound into bplc_ctrl; all resets synchronous, high
`timescale 1ns/1ps
`default_nettype none
module bplc_ctrl_monitor (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic link_reset,
	input wire logic global_reset_input,
	input wire bplc_pkg::bplc_cfg_req_s cfg_req,
	input wire bplc_pkg::bplc_txn_s txn,
	input wire logic txn_valid,
	input wire logic slot_power_short,
	input wire logic cfg_rvalid,
	input wire logic power_exceed_indicator_pin,
	input wire logic txn_unsupported,
	input wire logic txn_prefetchable,
	input wire logic txn_done,
	input wire logic virtual_channel_struct_present
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst || link_reset || global_reset_input);
	// two quiet cycles, so the one-cycle lag of the indicator has run out
	sequence limit_ok_s;
		!slot_power_short [*2];
	endsequence
	read_answer_a: assert property (cfg_req.valid && !cfg_req.write |=> cfg_rvalid) else $error("no read answer");
	txn_answer_a: assert property (txn_valid |=> txn_done) else $error("no txn answer");
	cfg_pass_a: assert property (
		txn_valid && (txn.is_config || txn.is_slot_power_msg) |=> !txn_unsupported) else $error("config refused");
	line_fetch_a: assert property (
		txn_valid && !slot_power_short && (txn.is_mem_read_line || txn.is_mem_read_multiple)
		|=> txn_prefetchable) else $error("line read not prefetchable");
	vc_zero_a: assert property (!virtual_channel_struct_present) else $error("vc flag set");
	ind_cause_a: assert property (
		$rose(power_exceed_indicator_pin) |-> $past(slot_power_short)) else $error("indicator without cause");
	ind_drop_a: assert property (limit_ok_s |=> !power_exceed_indicator_pin) else $error("indicator stuck");
	unsup_cause_a: assert property (
		$rose(txn_unsupported) |-> $past(slot_power_short) || $past(slot_power_short, 2)) else $error("bad refusal");
endmodule // bplc_ctrl_monitor
bind bplc_ctrl bplc_ctrl_monitor bplc_ctrl_monitor_i (
	.core_clk(core_clk),
	.sys_rst(sys_rst),
	.link_reset(link_reset),
	.global_reset_input(global_reset_input),
	.cfg_req(cfg_req),
	.txn(txn),
	.txn_valid(txn_valid),
	.slot_power_short(slot_power_short),
	.cfg_rvalid(cfg_rvalid),
	.power_exceed_indicator_pin(power_exceed_indicator_pin),
	.txn_unsupported(txn_unsupported),
	.txn_prefetchable(txn_prefetchable),
	.txn_done(txn_done),
	.virtual_channel_struct_present(virtual_channel_struct_present)
);
`default_nettype wire

// *** tb/bplc_ctrl_tb_top.sv ***
// bplc_ctrl_tb_top: register and action tests of the general control fields
// assumes the host model issues config requests; the bench drives the rest
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module bplc_ctrl_tb_top;
	logic core_clk = 0, sys_rst = 1, link_reset = 0, global_reset_input = 0, aux_por = 1;
	logic txn_valid = 0, slot_power_short = 0, in_d3 = 0, wake_request = 0;
	bplc_pkg::bplc_txn_s txn = '0;
	bplc_pkg::bplc_cfg_req_s cfg_req;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid, power_exceed_indicator_pin, txn_unsupported, txn_prefetchable, txn_done;
	logic virtual_channel_struct_present, wake_sideband_out, wake_beacon_out;
	logic [6:0] secondary_clock_enable;
	logic [2:0] advertised_standby_exit_latency, advertised_deep_idle_exit_latency;
	int failures = 0, samples_checked = 0, cycles = 0;
	initial forever #4 core_clk = ~core_clk;
	bplc_host_model bplc_host_model_i (.core_clk(core_clk), .cfg_req(cfg_req));
	bplc_ctrl bplc_ctrl_i (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.link_reset(link_reset),
		.global_reset_input(global_reset_input),
		.aux_por(aux_por),
		.cfg_req(cfg_req),
		.txn(txn),
		.txn_valid(txn_valid),
		.slot_power_short(slot_power_short),
		.in_d3(in_d3),
		.wake_request(wake_request),
		.cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid),
		.power_exceed_indicator_pin(power_exceed_indicator_pin),
		.secondary_clock_enable(secondary_clock_enable),
		.txn_unsupported(txn_unsupported),
		.txn_prefetchable(txn_prefetchable),
		.txn_done(txn_done),
		.advertised_standby_exit_latency(advertised_standby_exit_latency),
		.advertised_deep_idle_exit_latency(advertised_deep_idle_exit_latency),
		.virtual_channel_struct_present(virtual_channel_struct_present),
		.wake_sideband_out(wake_sideband_out),
		.wake_beacon_out(wake_beacon_out)
	);
	task automatic end_sim();
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// outputs follow a write one edge after the taking edge
	task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge core_clk);
		bplc_host_model_i.xfer(a, 1'b1, be, d);
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge core_clk);
		bplc_host_model_i.xfer(a, 1'b0, 4'hf, 32'h0);
		#1;
		`CHK(cfg_rvalid, 1'b1)
		`CHK(cfg_rdata, e)
	endtask
	task automatic tx(input bplc_pkg::bplc_txn_s t, input logic us);
		@(posedge core_clk);
		txn <= t;
		txn_valid <= 1'b1;
		@(posedge core_clk);
		txn_valid <= 1'b0;
		#1;
		`CHK({txn_done, txn_unsupported}, {1'b1, us})
	endtask
	task automatic lv(input logic s, input logic d, input logic w);
		@(posedge core_clk);
		slot_power_short <= s;
		in_d3 <= d;
		wake_request <= w;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task automatic pulse(input logic l, input logic g, input logic a);
		@(posedge core_clk);
		{link_reset, global_reset_input, aux_por} <= {l, g, a};
		@(posedge core_clk);
		{link_reset, global_reset_input, aux_por} <= 3'b000;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		aux_por <= 1'b0;
		rd(12'h0d4, 32'h0);
		rd(12'h0d0, 32'h0);
		wr(12'h0d4, 4'h6, 32'h001ddc00);
		rd(12'h0d4, 32'h001dcc00);
		`CHK({advertised_standby_exit_latency, advertised_deep_idle_exit_latency}, 6'h2e)
		`CHK(virtual_channel_struct_present, 1'b0)
		wr(12'h0d4, 4'h0, 32'hffffffff);
		rd(12'h0d4, 32'h001dcc00);
		tx(5'b00100, 1'b0);
		`CHK(txn_prefetchable, 1'b0)
		tx(5'b00010, 1'b0);
		`CHK(txn_prefetchable, 1'b1)
		lv(1'b0, 1'b1, 1'b0);
		`CHK({secondary_clock_enable, wake_sideband_out, wake_beacon_out}, 9'h000)
		lv(1'b0, 1'b0, 1'b1);
		`CHK({secondary_clock_enable, wake_sideband_out, wake_beacon_out}, 9'h1ff)
		pulse(1'b1, 1'b0, 1'b0);
		rd(12'h0d4, 32'h00000c00);
		tx(5'b00100, 1'b0);
		`CHK(txn_prefetchable, 1'b1)
		tx(5'b00001, 1'b0);
		`CHK(txn_prefetchable, 1'b1)
		pulse(1'b0, 1'b1, 1'b0);
		rd(12'h0d4, 32'h00000c00);
		pulse(1'b0, 1'b0, 1'b1);
		rd(12'h0d4, 32'h0);
		lv(1'b0, 1'b1, 1'b0);
		`CHK(secondary_clock_enable, 7'h7f)
		lv(1'b0, 1'b0, 1'b1);
		`CHK({wake_sideband_out, wake_beacon_out}, 2'b10)
		wr(12'h0d8, 4'h2, 32'h0000d500);
		rd(12'h0d8, 32'h00005500);
		lv(1'b1, 1'b0, 1'b0);
		for (int c = 0; c < 8; c++) begin
			wr(12'h0d4, 4'h4, 32'(c) << 20);
			`CHK(power_exceed_indicator_pin, (c == 1 || c == 3))
			`CHK(secondary_clock_enable, ((c == 2 || c == 3) ? 7'h2a : 7'h7f))
			tx(5'b00100, (c == 4));
			tx(5'b10000, 1'b0);
			tx(5'b01000, 1'b0);
		end
		end_sim();
	end
endmodule // bplc_ctrl_tb_top
`default_nettype wire
